// ### verilog/sasr_regs.sv
// Purpose: write-one-to-clear detect and alarm flags for four lvds banks
//    and sysref alignment, reached over axi4-lite
// Assumes: event inputs come from logic on aclk; lane clocks from pins
// Notes: a set and a clear in the same cycle leave the flag set
//
// Contract
// RULE_01: strobe per bank sets its seen flag
// RULE_02: strobe align request rise clears strobe flags
// RULE_03: sysref event sets sysref seen flag
// RULE_04: sysref align enable rise clears sysref flag
// RULE_05: fifo alarms only while input data toggles
// RULE_06: almost empty sets low alarm bit
// RULE_07: almost full sets high alarm bit
// RULE_08: disabled fifo never raises fifo alarms
// RULE_09: alarm bits clear on write one only
// RULE_10: enabled bank with stopped clock sets lost
// RULE_11: half edges missing in eight periods detected; code flags only more than half missing
// RULE_12: misplaced strobe sets its bank alarm
// RULE_13: misplaced strobe realigns fifo unless locked
// RULE_14: trigger divider realign sets its alarm
// RULE_15: sysref period multiple of trigger period
// RULE_16: wrong sysref alignment flagged when align off
// RULE_17: sysref or strobe clock realign sets alarm
// RULE_18: fifo alarm mask keeps fifo off alarm
// RULE_19: set beats simultaneous write-one clear
// RULE_20: flags reset zero, reserved bits read zero
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module sasr_regs #(
   parameter int NB = sasr_pkg::NUM_BANKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [sasr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sasr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core events and lane clocks
   input wire sasr_pkg::sasr_bank_ev_t bank_ev,
   input wire sasr_pkg::sasr_sys_ev_t sys_ev,
   input wire logic [NB-1:0] lane_clk,
   // effects on the core
   output logic [NB-1:0] fifo_realign,
   output logic sysref_align_enable,
   output logic alarm_out
);
   logic [NB-1:0] strobe_seen_flags_q; // detect flags per bank
   logic sysref_seen_flag_q;
   logic [NB-1:0] fifo_low_alarm_q;
   logic [NB-1:0] fifo_high_alarm_q;
   logic [NB-1:0] lane_clock_lost_alarm_q;
   logic [NB-1:0] strobe_misplaced_alarm_q;
   logic trig_realigned_q; // trigger divider realigned alarm
   logic sysref_misaligned_q;
   logic clocks_realigned_q;
   logic fifo_alarm_output_mask_q;
   logic sysref_align_enable_q;
   logic strobe_align_request_q;
   logic strobe_position_lock_q;
   logic [NB-1:0] fifo_enable_q;
   logic [NB-1:0] bank_enable_q;
   logic sysref_en_prev_q; // for rising-edge detection
   logic strobe_req_prev_q;
   logic [NB-1:0] clk_lost; // from the lane clock watchers
   logic wr_go; // address and data taken this cycle
   logic [sasr_pkg::IDX_W-1:0] wr_idx;
   logic [sasr_pkg::IDX_W-1:0] rd_idx;
   logic [7:0] wbyte; // write byte, zero when lane 0 is not strobed
   logic [7:0] clr_sync; // write-one clear masks per register
   logic [7:0] clr_fifo;
   logic [7:0] clr_lane;
   logic [7:0] clr_sys;
   logic [NB-1:0] fifo_ok; // banks allowed to raise fifo alarms
   logic wr_mapped;
   logic rd_mapped;
   logic [7:0] rd_byte;

   // ---------------- bus write side ----------------
   // address and data are taken together; simpler and still legal
   assign wr_go = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign wr_idx = s_axi_awaddr[sasr_pkg::ADDR_W-1:2];
   assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

   // decode which register a write hits
   always_comb begin
      clr_sync = 8'h00;
      clr_fifo = 8'h00;
      clr_lane = 8'h00;
      clr_sys = 8'h00;
      wr_mapped = 1'b1;
      if (wr_go) begin
         unique case (wr_idx)
            sasr_pkg::IDX_SYNC_DETECT: clr_sync = wbyte;
            sasr_pkg::IDX_FIFO_LEVEL: clr_fifo = wbyte;
            sasr_pkg::IDX_LANE_CLK_STRB: clr_lane = wbyte;
            sasr_pkg::IDX_SYS_ALIGN: clr_sys = wbyte;
            sasr_pkg::IDX_ALARM_MASK,
            sasr_pkg::IDX_SYNC_CTRL,
            sasr_pkg::IDX_BANK_CFG: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0; // unmapped: slverr
         endcase
      end
   end

   // write response, held until the master takes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sasr_pkg::RESP_OKAY;
      end else if (ce) begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? sasr_pkg::RESP_OKAY
                                     : sasr_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // plain read/write control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_alarm_output_mask_q <= 1'b0;
         sysref_align_enable_q <= 1'b0;
         strobe_align_request_q <= 1'b0;
         strobe_position_lock_q <= 1'b0;
         fifo_enable_q <= '0;
         bank_enable_q <= '0;
      end else if (ce && wr_go && s_axi_wstrb[0]) begin
         if (wr_idx == sasr_pkg::IDX_ALARM_MASK) begin
            fifo_alarm_output_mask_q <= wbyte[sasr_pkg::FIFO_MASK_BIT];
         end
         if (wr_idx == sasr_pkg::IDX_SYNC_CTRL) begin
            sysref_align_enable_q <= wbyte[sasr_pkg::CTRL_SYSREF_EN_BIT];
            strobe_align_request_q <= wbyte[sasr_pkg::CTRL_STRB_REQ_BIT];
            strobe_position_lock_q <= wbyte[sasr_pkg::CTRL_STRB_LOCK_BIT];
         end
         if (wr_idx == sasr_pkg::IDX_BANK_CFG) begin
            fifo_enable_q <= wbyte[sasr_pkg::CFG_FIFO_EN_LSB +: NB];
            bank_enable_q <= wbyte[sasr_pkg::CFG_BANK_EN_LSB +: NB];
         end
      end
   end

   assign sysref_align_enable = sysref_align_enable_q;

   // previous control levels, for the rising-edge clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysref_en_prev_q <= 1'b0;
         strobe_req_prev_q <= 1'b0;
      end else if (ce) begin
         sysref_en_prev_q <= sysref_align_enable_q;
         strobe_req_prev_q <= strobe_align_request_q;
      end
   end

   // ---------------- detect flags ----------------
   // sync detect flags; the set term is or-ed in last so it wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_seen_flags_q <= '0; // see RULE_20
         sysref_seen_flag_q <= 1'b0;
      end else if (ce) begin
         strobe_seen_flags_q <= (strobe_seen_flags_q
            & ~clr_sync[sasr_pkg::STROBE_SEEN_LSB +: NB]  // see RULE_01
            & ~{NB{strobe_align_request_q
                   && !strobe_req_prev_q}}) // see RULE_02
            | bank_ev.strobe_seen; // see RULE_01, see RULE_19
         sysref_seen_flag_q <= (sysref_seen_flag_q
            & ~clr_sync[sasr_pkg::SYSREF_SEEN_BIT]  // see RULE_03
            & ~(sysref_align_enable_q && !sysref_en_prev_q)) // see RULE_04
            | sys_ev.sysref_seen; // see RULE_03, see RULE_19
      end
   end

   // ---------------- fifo alarms ----------------
   // constant data or a disabled fifo can never raise an alarm
   assign fifo_ok = fifo_enable_q // see RULE_08
      & bank_ev.data_toggling; // see RULE_05

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_low_alarm_q <= '0;
         fifo_high_alarm_q <= '0;
      end else if (ce) begin
         fifo_low_alarm_q <= (fifo_low_alarm_q
            & ~clr_fifo[sasr_pkg::FIFO_LOW_LSB +: NB]) // see RULE_09
            | (bank_ev.fifo_almost_empty & fifo_ok); // see RULE_06
         fifo_high_alarm_q <= (fifo_high_alarm_q
            & ~clr_fifo[sasr_pkg::FIFO_HIGH_LSB +: NB]) // see RULE_09
            | (bank_ev.fifo_almost_full & fifo_ok); // see RULE_07
      end
   end

   // ---------------- lane clock and strobe alarms ----------------
   // one watcher per bank; each samples its own pin through two flops
   for (genvar b = 0; b < NB; b++) begin : g_watch
      sasr_clk_watch #(
         .WIN_CYC(sasr_pkg::WATCH_CYC),
         .MIN_EDGES(sasr_pkg::MIN_EDGES)
      ) u_watch (
         .aclk(aclk),
         .aresetn(aresetn),
         .ce(ce),
         .lane_clk(lane_clk[b]),
         .lost(clk_lost[b])
      );
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lane_clock_lost_alarm_q <= '0;
         strobe_misplaced_alarm_q <= '0;
      end else if (ce) begin
         lane_clock_lost_alarm_q <= (lane_clock_lost_alarm_q
            & ~clr_lane[sasr_pkg::CLK_LOST_LSB +: NB]) // see RULE_09
            | (clk_lost & bank_enable_q); // see RULE_10, see RULE_11
         strobe_misplaced_alarm_q <= (strobe_misplaced_alarm_q
            & ~clr_lane[sasr_pkg::STRB_MISPL_LSB +: NB]) // see RULE_09
            | bank_ev.strobe_misplaced; // see RULE_12
      end
   end

   // realign pulse per bank; the lock is sampled as the error arrives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_realign <= '0;
      end else if (ce) begin
         fifo_realign <= bank_ev.strobe_misplaced
            & ~{NB{strobe_position_lock_q}}; // see RULE_13
      end
   end

   // ---------------- system alignment alarms ----------------
   // relies on the sysref period matching the trigger divider (RULE_15),
   // otherwise the realign alarm keeps firing; see RULE_15
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_realigned_q <= 1'b0;
         sysref_misaligned_q <= 1'b0;
         clocks_realigned_q <= 1'b0;
      end else if (ce) begin
         trig_realigned_q <= (trig_realigned_q
            & ~clr_sys[sasr_pkg::TRIG_REALIGN_BIT]) // see RULE_09
            | sys_ev.trig_div_realign; // see RULE_14
         sysref_misaligned_q <= (sysref_misaligned_q
            & ~clr_sys[sasr_pkg::SYSREF_MISAL_BIT]) // see RULE_09
            | (sys_ev.sysref_wrong_align
               && !sysref_align_enable_q); // see RULE_16
         clocks_realigned_q <= (clocks_realigned_q
            & ~clr_sys[sasr_pkg::CLKS_REALIGN_BIT]) // see RULE_09
            | sys_ev.clocks_realign; // see RULE_17
      end
   end

   // alarm output: any alarm flag (not the detect flags), fifo flags gated by their mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_out <= 1'b0;
      end else if (ce) begin
         alarm_out <= (!fifo_alarm_output_mask_q
            && (|{fifo_low_alarm_q, fifo_high_alarm_q})) // see RULE_18
            || (|{lane_clock_lost_alarm_q, strobe_misplaced_alarm_q})
            || trig_realigned_q || sysref_misaligned_q
            || clocks_realigned_q;
      end
   end

   // ---------------- bus read side ----------------
   assign s_axi_arready = ce && !s_axi_rvalid;
   assign rd_idx = s_axi_araddr[sasr_pkg::ADDR_W-1:2];

   // read mux; reserved bits and unmapped words read as zero
   always_comb begin
      rd_byte = sasr_pkg::RST_BYTE; // see RULE_20
      rd_mapped = 1'b1;
      unique case (rd_idx)
         sasr_pkg::IDX_SYNC_DETECT: begin
            rd_byte[sasr_pkg::STROBE_SEEN_LSB +: NB] = strobe_seen_flags_q;
            rd_byte[sasr_pkg::SYSREF_SEEN_BIT] = sysref_seen_flag_q;
         end
         sasr_pkg::IDX_FIFO_LEVEL: begin
            rd_byte[sasr_pkg::FIFO_LOW_LSB +: NB] = fifo_low_alarm_q;
            rd_byte[sasr_pkg::FIFO_HIGH_LSB +: NB] = fifo_high_alarm_q;
         end
         sasr_pkg::IDX_LANE_CLK_STRB: begin
            rd_byte[sasr_pkg::CLK_LOST_LSB +: NB] = lane_clock_lost_alarm_q;
            rd_byte[sasr_pkg::STRB_MISPL_LSB +: NB] = strobe_misplaced_alarm_q;
         end
         sasr_pkg::IDX_SYS_ALIGN: begin
            rd_byte[sasr_pkg::TRIG_REALIGN_BIT] = trig_realigned_q;
            rd_byte[sasr_pkg::SYSREF_MISAL_BIT] = sysref_misaligned_q;
            rd_byte[sasr_pkg::CLKS_REALIGN_BIT] = clocks_realigned_q;
         end
         sasr_pkg::IDX_ALARM_MASK: begin
            rd_byte[sasr_pkg::FIFO_MASK_BIT] = fifo_alarm_output_mask_q;
         end
         sasr_pkg::IDX_SYNC_CTRL: begin
            rd_byte[sasr_pkg::CTRL_SYSREF_EN_BIT] = sysref_align_enable_q;
            rd_byte[sasr_pkg::CTRL_STRB_REQ_BIT] = strobe_align_request_q;
            rd_byte[sasr_pkg::CTRL_STRB_LOCK_BIT] = strobe_position_lock_q;
         end
         sasr_pkg::IDX_BANK_CFG: begin
            rd_byte[sasr_pkg::CFG_FIFO_EN_LSB +: NB] = fifo_enable_q;
            rd_byte[sasr_pkg::CFG_BANK_EN_LSB +: NB] = bank_enable_q;
         end
         default: rd_mapped = 1'b0;
      endcase
   end

   // read data registered, held until the master takes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= sasr_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_mapped ? sasr_pkg::RESP_OKAY
                                     : sasr_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ### verilog/sasr_pkg.sv
// Purpose: shared constants and types for the sync alarm status registers
// Assumes: 32-bit axi4-lite data, registers in the low byte of each word
// Notes: register offsets are word indices; byte address is four times these
package sasr_pkg;
   localparam int NUM_BANKS = 4;
   localparam int ADDR_W = 14;
   localparam int IDX_W = 12;
   // register indices
   localparam logic [IDX_W-1:0] IDX_SYNC_DETECT = 12'h800;
   localparam logic [IDX_W-1:0] IDX_FIFO_LEVEL = 12'h820;
   localparam logic [IDX_W-1:0] IDX_LANE_CLK_STRB = 12'h821;
   localparam logic [IDX_W-1:0] IDX_SYS_ALIGN = 12'h822;
   localparam logic [IDX_W-1:0] IDX_ALARM_MASK = 12'h823;
   localparam logic [IDX_W-1:0] IDX_SYNC_CTRL = 12'h830;
   localparam logic [IDX_W-1:0] IDX_BANK_CFG = 12'h831;
   // field positions
   localparam int STROBE_SEEN_LSB = 4;
   localparam int SYSREF_SEEN_BIT = 0;
   localparam int FIFO_LOW_LSB = 4;
   localparam int FIFO_HIGH_LSB = 0;
   localparam int CLK_LOST_LSB = 4;
   localparam int STRB_MISPL_LSB = 0;
   localparam int TRIG_REALIGN_BIT = 2;
   localparam int SYSREF_MISAL_BIT = 1;
   localparam int CLKS_REALIGN_BIT = 0;
   localparam int FIFO_MASK_BIT = 7;
   localparam int CTRL_SYSREF_EN_BIT = 0;
   localparam int CTRL_STRB_REQ_BIT = 1;
   localparam int CTRL_STRB_LOCK_BIT = 2;
   localparam int CFG_FIFO_EN_LSB = 4;
   localparam int CFG_BANK_EN_LSB = 0;
   // reset values and response codes
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: aclk period and nominal lane clock period
   localparam int CLK_PERIOD_NS = 20;
   localparam int LANE_PERIOD_NS = 80;
   localparam int LANE_PERIOD_CYC =
      (LANE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WATCH_PERIODS = 8;
   localparam int WATCH_CYC = WATCH_PERIODS * LANE_PERIOD_CYC;
   // edges expected in a window: two per period, half must be present
   localparam int MIN_EDGES = WATCH_PERIODS;

   // per-bank event strobes from core logic on aclk
   typedef struct packed {
      logic [NUM_BANKS-1:0] strobe_seen;
      logic [NUM_BANKS-1:0] strobe_misplaced;
      logic [NUM_BANKS-1:0] fifo_almost_empty;
      logic [NUM_BANKS-1:0] fifo_almost_full;
      logic [NUM_BANKS-1:0] data_toggling;
   } sasr_bank_ev_t;

   // system-wide alignment events
   typedef struct packed {
      logic sysref_seen;
      logic trig_div_realign;
      logic sysref_wrong_align;
      logic clocks_realign;
   } sasr_sys_ev_t;
endpackage

// ### verilog/sasr_clk_watch.sv
// Purpose: flags a stopped lane clock by counting its edges in a window
// Assumes: lane clock is slower than aclk and arrives from a pin
// Notes: lost is re-evaluated at the end of every window
`timescale 1ns/100ps
module sasr_clk_watch #(
   parameter int WIN_CYC = sasr_pkg::WATCH_CYC,
   parameter int MIN_EDGES = sasr_pkg::MIN_EDGES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic lane_clk,
   output logic lost
);
   logic sync1_q; // first stage, read only by sync2_q
   logic sync2_q;
   logic prev_q; // delayed copy for edge detection
   logic [15:0] win_q; // cycles elapsed in the current window
   logic [15:0] edges_q; // edges seen in the current window
   logic edge_hit;

   // two flip-flops before the lane clock is looked at
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce) begin
         sync1_q <= lane_clk;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign edge_hit = sync2_q ^ prev_q; // both edges count

   // window counter; more than half the edges missing marks the clock lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_q <= 16'h0000;
         edges_q <= 16'h0000;
         lost <= 1'b0;
      end else if (ce) begin
         if (win_q == 16'(WIN_CYC - 1)) begin
            win_q <= 16'h0000;
            edges_q <= 16'h0000;
            // see RULE_11
            lost <= (edges_q + 16'(edge_hit)) < 16'(MIN_EDGES);
         end else begin
            win_q <= win_q + 16'h0001;
            edges_q <= edges_q + 16'(edge_hit);
         end
      end
   end
endmodule

// ### verif/sasr_regs_sva.sv
// Purpose: port assertions for the sync alarm register block
// Assumes: one aclk domain, synchronous active-low aresetn
// Notes: event checks expect ce high for two cycles
`timescale 1ns/100ps
module sasr_regs_chk #(
   parameter int NB = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire sasr_pkg::sasr_bank_ev_t bank_ev,
   input wire sasr_pkg::sasr_sys_ev_t sys_ev,
   input wire logic [NB-1:0] fifo_realign,
   input wire logic sysref_align_enable,
   input wire logic alarm_out
);
   // every check samples on aclk and sleeps through reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans)
      else $error("write not answered");
   // reserved upper bits must come back zero
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready
         |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h000000);
   endproperty
   a_rd_ans: assert property (p_rd_ans)
      else $error("read answer late or upper bits set");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped before taken");
   // a realign pulse needs a misplaced strobe one cycle before
   property p_realign_src;
      $past(ce) |-> (fifo_realign & ~$past(bank_ev.strobe_misplaced)) == '0;
   endproperty
   a_realign_src: assert property (p_realign_src)
      else $error("realign without misplaced strobe");
   property p_realign_end;
      ce && fifo_realign != '0 && bank_ev.strobe_misplaced == '0
         |=> fifo_realign == '0;
   endproperty
   a_realign_end: assert property (p_realign_end)
      else $error("realign pulse too long");
   property p_strb_alm;
      ce && bank_ev.strobe_misplaced != '0 ##1 ce |=> alarm_out;
   endproperty
   a_strb_alm: assert property (p_strb_alm)
      else $error("misplaced strobe raised no alarm");
   property p_system_alignment_alarms;
      ce && (sys_ev.trig_div_realign || sys_ev.clocks_realign) ##1 ce
         |=> alarm_out;
   endproperty
   a_system_alignment_alarms: assert property (p_system_alignment_alarms)
      else $error("realign event raised no alarm");
   // alarms only go away after a register write
   property p_alm_fall;
      $fell(alarm_out) |-> $past(s_axi_bvalid);
   endproperty
   a_alm_fall: assert property (p_alm_fall)
      else $error("alarm fell without a write");
   property p_en_write;
      $changed(sysref_align_enable) |-> s_axi_bvalid;
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("align enable moved without a write");
   c_wr: cover property (s_axi_awvalid && s_axi_awready);
   c_realign: cover property (fifo_realign != '0);
   c_fall: cover property ($fell(alarm_out));
endmodule

bind sasr_regs sasr_regs_chk #(.NB(NB)) u_sasr_regs_chk (
   .aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .bank_ev(bank_ev), .sys_ev(sys_ev), .fifo_realign(fifo_realign),
   .sysref_align_enable(sysref_align_enable), .alarm_out(alarm_out)
);

// ### verif/sasr_lane_src.sv
// Purpose: source-side model of the four lane clocks
// Assumes: nominal 80 ns lane period
// Notes: a stopped lane stands at its last level, like a dead source
`timescale 1ns/100ps
module sasr_lane_src #(
   parameter int HALF_NS = 40
) (
   input wire logic [3:0] stop,
   output wire logic [3:0] lane_clk
);
   // each half period is i ns longer per lane; lanes 1-3 drift against aclk, lane 0 stays in step
   for (genvar i = 0; i < 4; i++) begin : g_lane
      logic clk_q = 1'b0; // this lane's clock level
      always #(HALF_NS + i) begin
         if (!stop[i]) begin
            clk_q = ~clk_q;
         end
      end
      assign lane_clk[i] = clk_q;
   end
endmodule

// ### verif/tb.sv
// Purpose: register-level test of the sync alarm status block
// Assumes: events driven here on aclk, lane clocks from the source model
// Notes: byte address is four times the register index
`timescale 1ns/100ps
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1; // kept running so event timing stays visible
   logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sys_en, alarm_out;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] lane_clk, fifo_realign;
   logic [3:0] stop = 4'h0; // lanes the source holds still
   logic [1:0] eresp = sasr_pkg::RESP_OKAY; // response next access expects
   sasr_pkg::sasr_bank_ev_t bank_ev = '0;
   sasr_pkg::sasr_sys_ev_t sys_ev = '0;
   int fails = 0, total_checks = 0;

   sasr_regs u_sasr_regs (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bank_ev(bank_ev),
      .sys_ev(sys_ev), .lane_clk(lane_clk), .fifo_realign(fifo_realign),
      .sysref_align_enable(sys_en), .alarm_out(alarm_out)
   );
   sasr_lane_src u_sasr_lane_src (.stop(stop), .lane_clk(lane_clk));

   always #10 aclk = ~aclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // address and data offered together, held until both are taken
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, eresp});
   endtask
   task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, eresp});
   endtask
   // one-cycle event on the core inputs
   task automatic ev(input logic [19:0] b, input logic [3:0] s);
      @(posedge aclk);
      bank_ev <= b;
      sys_ev <= s;
      @(posedge aclk);
      bank_ev <= '0;
      sys_ev <= '0;
   endtask

   // cut a hang short well past the expected run of a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(sasr_pkg::IDX_SYNC_DETECT, 32'h0);
      rd(sasr_pkg::IDX_FIFO_LEVEL, 32'h0);
      rd(sasr_pkg::IDX_LANE_CLK_STRB, 32'h0);
      rd(sasr_pkg::IDX_SYS_ALIGN, 32'h0);
      // an unmapped word errors, reads zero and ignores the write
      eresp = sasr_pkg::RESP_SLVERR;
      wr(12'h801, 8'hFF);
      rd(12'h801, 32'h0);
      eresp = sasr_pkg::RESP_OKAY;
      // banks 0-2 in use with fifos on; bank 3 left off
      wr(sasr_pkg::IDX_BANK_CFG, 8'h77);
      // single sysref pulse, never a train off the trigger grid
      ev(20'hA0000, 4'h8);
      rd(sasr_pkg::IDX_SYNC_DETECT, 32'hA1);
      wr(sasr_pkg::IDX_SYNC_DETECT, 8'h20);
      wr(sasr_pkg::IDX_SYNC_DETECT, 8'h00);
      rd(sasr_pkg::IDX_SYNC_DETECT, 32'h81);
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h02);
      rd(sasr_pkg::IDX_SYNC_DETECT, 32'h01);
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h03);
      rd(sasr_pkg::IDX_SYNC_DETECT, 32'h00);
      chk(32'(sys_en), 32'h1);
      // fifo levels: quiet data first, then toggling data
      ev(20'h00FF0, 4'h0);
      rd(sasr_pkg::IDX_FIFO_LEVEL, 32'h00);
      ev(20'h00FFF, 4'h0);
      rd(sasr_pkg::IDX_FIFO_LEVEL, 32'h77);
      wr(sasr_pkg::IDX_FIFO_LEVEL, 8'h0F);
      rd(sasr_pkg::IDX_FIFO_LEVEL, 32'h70);
      wr(sasr_pkg::IDX_ALARM_MASK, 8'h80);
      repeat (3) @(negedge aclk);
      chk(32'(alarm_out), 32'h0);
      wr(sasr_pkg::IDX_ALARM_MASK, 8'h00);
      repeat (3) @(negedge aclk);
      chk(32'(alarm_out), 32'h1);
      wr(sasr_pkg::IDX_FIFO_LEVEL, 8'hF0);
      repeat (3) @(negedge aclk);
      chk(32'(alarm_out), 32'h0);
      // misplaced strobes, unlocked then locked
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h00);
      ev(20'h02000, 4'h0);
      @(negedge aclk);
      chk(32'(fifo_realign), 32'h2);
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h04);
      ev(20'h01000, 4'h0);
      @(negedge aclk);
      chk(32'(fifo_realign), 32'h0);
      rd(sasr_pkg::IDX_LANE_CLK_STRB, 32'h03);
      // clear and new event at the same edge: the event must survive
      fork
         wr(sasr_pkg::IDX_LANE_CLK_STRB, 8'h01);
         ev(20'h01000, 4'h0);
      join
      rd(sasr_pkg::IDX_LANE_CLK_STRB, 32'h03);
      wr(sasr_pkg::IDX_LANE_CLK_STRB, 8'h03);
      // system alarms with alignment off, then wrong edge with it on
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h00);
      ev(20'h00000, 4'h7);
      rd(sasr_pkg::IDX_SYS_ALIGN, 32'h07);
      wr(sasr_pkg::IDX_SYS_ALIGN, 8'h07);
      wr(sasr_pkg::IDX_SYNC_CTRL, 8'h01);
      ev(20'h00000, 4'h2);
      rd(sasr_pkg::IDX_SYS_ALIGN, 32'h00);
      // lanes 2 and 3 stop; of the two only lane 2 is in use
      stop <= 4'hC;
      repeat (100) @(posedge aclk);
      rd(sasr_pkg::IDX_LANE_CLK_STRB, 32'h40);
      stop <= 4'h0;
      repeat (100) @(posedge aclk);
      wr(sasr_pkg::IDX_LANE_CLK_STRB, 8'hF0);
      rd(sasr_pkg::IDX_LANE_CLK_STRB, 32'h00);
      final_report();
   end
endmodule
